//--- bench/cam_output_mode_checker.sv
// assertions on the output mode block ports
`timescale 1ns/100ps
`default_nettype none
module cam_chk(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        bus_wr,
  input wire logic        counter_match,
  input wire logic        module_output_pin,
  input wire logic        match_capture_flag,
  input wire logic        match_irq_request,
  input wire logic [1:0]  bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] counter_value
);
  // shadows follow the same one-cycle write timing as the block itself
  logic [3:0] m = 4'h0;
  logic [15:0] c = 16'h0000;
  wire logic p = module_output_pin, hit = counter_value[7:0] == c[7:0];
  wire logic fe = match_capture_flag & m[0], tg = m[2:1] == 2'h2, pw = m[2:1] == 2'h1;
  wire logic ge = m[3] ? counter_value >= c : counter_value[7:0] >= c[7:0];
  always @(posedge sys_clk) if (!rst_n) m <= 4'h0; else if (bus_wr && bus_addr == 2'h0) m <= bus_wdata[3:0];
  always @(posedge sys_clk) if (!rst_n) c <= 16'h0000; else if (bus_wr && bus_addr == 2'h1) c <= bus_wdata;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_TOG: assert property (tg && counter_match |=> $changed(p)) else $error("tog");
  AST_PWM: assert property (pw |=> p == $past(ge)) else $error("pwm");
  AST_OFF: assert property (m[2:1] == 2'h0 |=> $stable(p)) else $error("off");
  AST_FRQ: assert property (&m[2:1] && hit |=> $changed(p)) else $error("frq");
  AST_IRQ: assert property (match_irq_request == $past(fe)) else $error("irq");
  AST_FLG: assert property (counter_match |=> match_capture_flag) else $error("flg");
  cover property (m == 4'hA && p);
  cover property (match_irq_request);
  cover property (&m[2:1] && hit);
endmodule // cam_chk
`default_nettype wire

//--- bench/cam_pin_load.sv
// load on the module output pin, counting its rising edges
`timescale 1ns/100ps
`default_nettype none
module cam_pin_load(input wire logic sys_clk, module_output_pin,
  output var logic [7:0] rises = 8'h00);
  always @(posedge sys_clk) rises <= rises + 8'($rose(module_output_pin));
endmodule // cam_pin_load
`default_nettype wire

//--- bench/test_cam_output_mode.sv
// self-checking bench for the output mode block
`timescale 1ns/100ps
`default_nettype none
module test_cam_output_mode;
  logic sys_clk = 0, rst_n = 0, bus_wr = 0, bus_rd = 0, counter_match = 0, capture_event = 0;
  logic [1:0] bus_addr = 2'h0;
  logic [15:0] bus_wdata = 16'h0000, counter_value = 16'h0000, bus_rdata;
  logic module_output_pin, match_capture_flag, match_irq_request, o;
  logic [7:0] rises;
  int n_errors = 0, checks = 0;
  logic [20:0] rows [4] = '{{4'h2, 16'h0080, 1'h1}, {4'h2, 16'h017F, 1'h0},
    {4'hA, 16'h017F, 1'h0}, {4'hA, 16'h0180, 1'h1}};
  cam_output_mode DUT(.*);
  cam_pin_load load(.*);
  task close_out;
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] g, e);
    checks++;
    if (g !== e) begin n_errors++; $display("ERROR %0t got %h not %h", $time, g, e); end
  endtask
  // a match raised before a call is dropped on the request edge, so it lasts one sample
  task acc(input logic w, input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk) {bus_wr, bus_rd, bus_addr, bus_wdata, counter_match}
      <= {w, !w, a, d, 1'h0};
    @(posedge sys_clk) {bus_wr, bus_rd} <= 2'h0;
    #1 if (!w) chk(bus_rdata, d);
  endtask
  initial forever #4 sys_clk = ~sys_clk;
  initial begin repeat (600) @(posedge sys_clk); n_errors++; close_out; end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    acc(0, 2'h2, 16'h0000);
    acc(1, 2'h1, 16'h0180);
    foreach (rows[i]) begin
      acc(1, 2'h0, {12'h000, rows[i][20:17]});
      @(posedge sys_clk) counter_value <= rows[i][16:1];
      @(posedge sys_clk) #1 chk(module_output_pin, rows[i][0]);
    end
    acc(1, 2'h0, 16'h0005);
    counter_match <= 1'h1;
    acc(0, 2'h2, 16'h0001);
    chk(match_irq_request, 16'h0001);
    acc(1, 2'h2, 16'h0001);
    acc(1, 2'h0, 16'h0004);
    counter_match <= 1'h1;
    acc(0, 2'h2, 16'h0003);
    chk({match_irq_request, rises}, 16'h0003);
    acc(0, 2'h3, 16'h0000);
    acc(1, 2'h0, 16'h0006);
    o = module_output_pin;
    @(posedge sys_clk) #1 chk(module_output_pin, !o);
    @(posedge sys_clk) rst_n <= 1'h0;
    @(posedge sys_clk) rst_n <= 1'h1;
    #1 chk({module_output_pin, match_capture_flag, match_irq_request}, 16'h0000);
    @(posedge sys_clk) capture_event <= 1'h1;
    @(posedge sys_clk) capture_event <= 1'h0;
    acc(0, 2'h2, 16'h0001);
    acc(1, 2'h2, 16'h0001);
    @(posedge sys_clk) {capture_event, bus_wr, bus_addr, bus_wdata} <= {1'h1, 1'h1, 2'h2, 16'h0001};
    @(posedge sys_clk) {capture_event, bus_wr} <= 2'h0;
    acc(0, 2'h2, 16'h0001);
    close_out;
  end
endmodule // test_cam_output_mode
bind cam_output_mode cam_chk u_chk(.*);
`default_nettype wire

//--- hw/cam_defs.vh
// constants for the counter array module output mode block
`ifndef CAM_DEFS_VH
`define CAM_DEFS_VH
`define CAM_ADDR_W         2
`define CAM_ADDR_MODE      2'h0
`define CAM_ADDR_CMP       2'h1
`define CAM_ADDR_STATUS    2'h2
`define CAM_BIT_IRQ_EN     0
`define CAM_BIT_PWM_EN     1
`define CAM_BIT_TOGGLE_EN  2
`define CAM_BIT_WIDE_PWM   3
`define CAM_MODE_RESET     4'h0
`define CAM_CMP_RESET      16'h0000
`define CAM_LOW_BYTE_MASK  16'h00FF
`define CAM_DATA_W         16
`define CAM_MODE_W         4
`define CAM_BYTE_W         8
`define CAM_STATUS_FLAG    0
`define CAM_STATUS_PIN     1
`define CAM_RDATA_RESET    16'h0000
`define CAM_BIT_RESET      1'h0
`endif

//--- hw/cam_output_mode.v
// output mode and flag masking logic for one counter array capture/compare module
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "cam_defs.vh"
module cam_output_mode #(
  parameter CNT_W = 16
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [`CAM_ADDR_W-1:0] bus_addr,
  input  wire [15:0]      bus_wdata,
  input  wire             bus_wr,
  input  wire             bus_rd,
  output reg  [15:0]      bus_rdata,
  input  wire [CNT_W-1:0] counter_value,
  input  wire             counter_match,
  input  wire             capture_event,
  output reg              module_output_pin,
  output reg              match_capture_flag,
  output reg              match_irq_request
);

  // widths held local so the counter can be sized apart from the bus
  localparam DATA_W = `CAM_DATA_W;
  localparam MODE_W = `CAM_MODE_W;
  localparam BYTE_W = `CAM_BYTE_W;

  // one-hot codes for the behaviour that the mode bits select
  localparam [3:0] OUT_HOLD   = 4'h1;
  localparam [3:0] OUT_TOGGLE = 4'h2;
  localparam [3:0] OUT_PWM    = 4'h4;
  localparam [3:0] OUT_FREQ   = 4'h8;

  reg  [MODE_W-1:0] mode;
  reg  [CNT_W-1:0]  compare_value;
  reg               next_pin;
  reg               next_flag;
  reg               next_irq;
  reg  [DATA_W-1:0] next_rdata;
  reg  [DATA_W-1:0] status_word;
  wire [DATA_W-1:0] mode_word;
  wire [3:0]        out_sel;
  wire              match_toggle_enable;
  wire              pulse_width_enable;
  wire              wide_pwm_select;
  wire              match_flag_irq_enable;
  wire [BYTE_W-1:0] counter_low;
  wire [BYTE_W-1:0] compare_low;
  wire              low_equal;
  wire              low_reached;
  wire              wide_reached;
  wire              mode_write;
  wire              cmp_write;
  wire              status_write;
  wire              flag_set;
  wire              flag_clear;

  // low byte of a count, shared by the 8-bit pwm and frequency compares
  function [BYTE_W-1:0] low_byte;
    input [CNT_W-1:0] value;
    begin
      low_byte = value[BYTE_W-1:0];
    end
  endfunction

  // bus word to counter width; pads or trims on purpose
  function [CNT_W-1:0] to_count;
    input [DATA_W-1:0]       value;
    reg   [DATA_W+CNT_W-1:0] both;
    begin
      both     = {{CNT_W{1'h0}}, value};
      to_count = both[CNT_W-1:0];
    end
  endfunction

  // counter width to bus word; a wider counter reads back trimmed
  function [DATA_W-1:0] to_data;
    input [CNT_W-1:0]        value;
    reg   [DATA_W+CNT_W-1:0] both;
    begin
      both    = {{DATA_W{1'h0}}, value};
      to_data = both[DATA_W-1:0];
    end
  endfunction

  // both enables together outrank either one alone
  function [3:0] decode_mode;
    input toggle_on;
    input pwm_on;
    begin
      if (toggle_on && pwm_on) begin
        decode_mode = OUT_FREQ;
      end else if (pwm_on) begin
        decode_mode = OUT_PWM;
      end else if (toggle_on) begin
        decode_mode = OUT_TOGGLE;
      end else begin
        decode_mode = OUT_HOLD;
      end
    end
  endfunction

  assign match_toggle_enable   = mode[`CAM_BIT_TOGGLE_EN];
  assign pulse_width_enable    = mode[`CAM_BIT_PWM_EN];
  assign wide_pwm_select       = mode[`CAM_BIT_WIDE_PWM];
  assign match_flag_irq_enable = mode[`CAM_BIT_IRQ_EN];

  assign out_sel      = decode_mode(match_toggle_enable, pulse_width_enable);
  assign counter_low  = low_byte(counter_value);
  assign compare_low  = low_byte(compare_value);
  assign low_equal    = (counter_low == compare_low);
  assign low_reached  = (counter_low >= compare_low);
  assign wide_reached = (counter_value >= compare_value);

  assign mode_write   = bus_wr && (bus_addr == `CAM_ADDR_MODE);
  assign cmp_write    = bus_wr && (bus_addr == `CAM_ADDR_CMP);
  assign status_write = bus_wr && (bus_addr == `CAM_ADDR_STATUS);
  assign flag_set     = counter_match || capture_event;
  assign flag_clear   = status_write && bus_wdata[`CAM_STATUS_FLAG];
  assign mode_word    = {{(DATA_W-MODE_W){1'h0}}, mode};

  // pwm holds the pin low until the count reaches the compare value, comparing low bytes only unless wide pwm is selected
  always @* begin
    next_pin = module_output_pin;
    case (out_sel)
      OUT_FREQ: begin
        // toggles on every cycle the low bytes agree
        if (low_equal) begin
          next_pin = ~module_output_pin;
        end
      end
      OUT_PWM: begin
        if (wide_pwm_select) begin
          next_pin = wide_reached;
        end else begin
          next_pin = low_reached;
        end
      end
      OUT_TOGGLE: begin
        if (counter_match) begin
          next_pin = ~module_output_pin;
        end
      end
      OUT_HOLD: begin
        next_pin = module_output_pin;
      end
      default: begin
        next_pin = module_output_pin;
      end
    endcase
  end

  // set beats a clear in the same cycle, so no event is lost; mask plays no part
  always @* begin
    next_flag = match_capture_flag;
    if (flag_set) begin
      next_flag = 1'h1;
    end else if (flag_clear) begin
      next_flag = 1'h0;
    end
  end

  // request trails the flag by one cycle and only while enabled
  always @* begin
    next_irq = 1'h0;
    if (match_flag_irq_enable) begin
      next_irq = match_capture_flag;
    end
  end

  always @* begin
    status_word                   = `CAM_RDATA_RESET;
    status_word[`CAM_STATUS_FLAG] = match_capture_flag;
    status_word[`CAM_STATUS_PIN]  = module_output_pin;
  end

  // read data stands in the cycle after each cycle of bus_rd and is zero otherwise
  always @* begin
    next_rdata = `CAM_RDATA_RESET;
    if (bus_rd) begin
      case (bus_addr)
        `CAM_ADDR_MODE: begin
          next_rdata = mode_word;
        end
        `CAM_ADDR_CMP: begin
          next_rdata = to_data(compare_value);
        end
        `CAM_ADDR_STATUS: begin
          next_rdata = status_word;
        end
        default: begin
          next_rdata = `CAM_RDATA_RESET;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      mode <= `CAM_MODE_RESET;
    end else if (mode_write) begin
      mode <= bus_wdata[MODE_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      compare_value <= to_count(`CAM_CMP_RESET);
    end else if (cmp_write) begin
      compare_value <= to_count(bus_wdata);
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      module_output_pin <= `CAM_BIT_RESET;
    end else begin
      module_output_pin <= next_pin;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      match_capture_flag <= `CAM_BIT_RESET;
    end else begin
      match_capture_flag <= next_flag;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      match_irq_request <= `CAM_BIT_RESET;
    end else begin
      match_irq_request <= next_irq;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_rdata <= `CAM_RDATA_RESET;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

endmodule // cam_output_mode
`default_nettype wire
